// File: rtl/idsu_pkg.sv
// package for the integer divide and double-shift unit
package idsu_pkg;
   // ***********************************************************
   // operation codes and widths
   // ***********************************************************
   typedef enum logic [2:0] {
      IDSU_OP_DIVU = 3'h0,
      IDSU_OP_DIVS = 3'h1,
      IDSU_OP_DSHL = 3'h2,
      IDSU_OP_DSHR = 3'h3
   } idsu_op_t;

   typedef enum logic [1:0] {
      IDSU_W8 = 2'h0,
      IDSU_W16 = 2'h1,
      IDSU_W32 = 2'h2,
      IDSU_W64 = 2'h3
   } idsu_width_t;

   // ***********************************************************
   // latency figures in cycles
   // ***********************************************************
   localparam int IDSU_ENH_MIN = 11;
   localparam int IDSU_ENH_B_MAX = 12;
   localparam int IDSU_ENH_UC_MIN = 12;
   localparam int IDSU_ENH_H_MAX = 17;
   localparam int IDSU_ENH_W_MAX = 25;
   localparam int IDSU_ENH_Q_MAX = 41;
   localparam int IDSU_BU_B = 25;
   localparam int IDSU_BU_H_MIN = 26;
   localparam int IDSU_BU_H_MAX = 30;
   localparam int IDSU_BU_W_MIN = 26;
   localparam int IDSU_BU_W_MAX = 38;
   localparam int IDSU_BU_Q_MIN = 38;
   localparam int IDSU_BU_Q_MAX = 123;
   localparam int IDSU_BS_B = 34;
   localparam int IDSU_BS_H_MIN = 35;
   localparam int IDSU_BS_H_MAX = 40;
   localparam int IDSU_BS_W_MIN = 35;
   localparam int IDSU_BS_W_MAX = 47;
   localparam int IDSU_BS_Q_MIN = 49;
   localparam int IDSU_BS_Q_MAX = 135;
   localparam int IDSU_SHIFT_HW_LAT = 1;
   localparam int IDSU_SHIFT_UC_LAT = 8;
   localparam int IDSU_CNT_W = 8;

   // ***********************************************************
   // request and result carriers
   // ***********************************************************
   typedef struct packed {
      idsu_op_t op;
      idsu_width_t width;
      logic mem_dst;
      logic cnt_from_reg;
      logic cnt_fresh;
      logic [7:0] shamt;
      logic [63:0] hi;
      logic [63:0] lo;
      logic [63:0] src;
   } idsu_req_t;

   typedef struct packed {
      logic [63:0] lo;
      logic [63:0] hi;
      logic exc;
      logic microcoded;
   } idsu_rsp_t;
endpackage

// File: rtl/idsu_unit.sv
// integer divide and double-shift execution unit
// Behaviour
// RULE1: unsigned divide takes hi:lo dividend and a divisor, quotient goes low and remainder high, enhanced 11-12 to 12-41 cycles.
// RULE2: signed divide uses the same placement, baseline takes 34 cycles for bytes up to 49-135 for 64 bits.
// RULE3: enhanced variant runs byte divides fully in hardware with no microcode.
// RULE4: enhanced variant runs wider divides through microcode with assist, 12-17, 12-25, 12-41 cycles.
// RULE5: baseline runs every divide as long microcode, unsigned 25 cycles for bytes up to 38-123 for 64 bits.
// RULE6: completion is signalled by a valid handshake, not a fixed count.
// RULE7: a busy level is driven each cycle while a divide is in flight, for event counting.
// RULE8: a shift whose count register was produced by the previous instruction waits exactly one idle cycle.
// RULE9: 64-bit double shifts run as long microcode flows.
// RULE10: enhanced variant runs 32-bit register immediate double shifts in hardware both directions.
// RULE11: baseline microcodes the 32-bit register immediate right double shift but not the left.
// RULE12: 32-bit memory-destination or count-register double shifts are microcoded in both variants.
// RULE13: zero divisor or overflowing quotient raises an exception and leaves the destination unchanged.
`timescale 1ns/1ns
module idsu_unit
   import idsu_pkg::*;
#(
   parameter bit ENHANCED = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   input idsu_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output idsu_rsp_t rsp,
   output logic div_busy
);
   typedef enum logic [3:0] {
      IDSU_IDLE = 4'h1,
      IDSU_BUBBLE = 4'h2,
      IDSU_RUN = 4'h4,
      IDSU_DONE = 4'h8
   } idsu_state_t;

   typedef struct packed {
      idsu_state_t st;
      idsu_req_t r;
      logic [7:0] cnt;
      logic is_div;
      idsu_rsp_t res;
   } idsu_st_t;

   idsu_st_t s_q, s_d;

   // ***********************************************************
   // value-dependent latency
   // ***********************************************************
   // latency scales with the highest set bit position found in lo or hi, the two halves ORed bit by bit over 64 bits
   function automatic logic [7:0] lat_of(input idsu_req_t r);
      logic [6:0] sig;
      int lo_l, hi_l;
      sig = 7'h00;
      lo_l = 0;
      hi_l = 0;
      for (int i = 0; i < 64; i++) begin
         if (r.lo[i] || r.hi[i]) begin
            sig = 7'(i + 1);
         end
      end
      if (ENHANCED) begin
         case (r.width)
            IDSU_W8: begin lo_l = IDSU_ENH_MIN; hi_l = IDSU_ENH_B_MAX; end // RULE1 RULE3
            IDSU_W16: begin lo_l = IDSU_ENH_UC_MIN; hi_l = IDSU_ENH_H_MAX; end // RULE4
            IDSU_W32: begin lo_l = IDSU_ENH_UC_MIN; hi_l = IDSU_ENH_W_MAX; end // RULE4
            default: begin lo_l = IDSU_ENH_UC_MIN; hi_l = IDSU_ENH_Q_MAX; end // RULE1 RULE4
         endcase
      end else if (r.op == IDSU_OP_DIVS) begin
         case (r.width)
            IDSU_W8: begin lo_l = IDSU_BS_B; hi_l = IDSU_BS_B; end // RULE2
            IDSU_W16: begin lo_l = IDSU_BS_H_MIN; hi_l = IDSU_BS_H_MAX; end // RULE2
            IDSU_W32: begin lo_l = IDSU_BS_W_MIN; hi_l = IDSU_BS_W_MAX; end // RULE2
            default: begin lo_l = IDSU_BS_Q_MIN; hi_l = IDSU_BS_Q_MAX; end // RULE2
         endcase
      end else begin
         case (r.width)
            IDSU_W8: begin lo_l = IDSU_BU_B; hi_l = IDSU_BU_B; end // RULE5
            IDSU_W16: begin lo_l = IDSU_BU_H_MIN; hi_l = IDSU_BU_H_MAX; end // RULE5
            IDSU_W32: begin lo_l = IDSU_BU_W_MIN; hi_l = IDSU_BU_W_MAX; end // RULE5
            default: begin lo_l = IDSU_BU_Q_MIN; hi_l = IDSU_BU_Q_MAX; end // RULE5
         endcase
      end
      lat_of = 8'(lo_l + ((hi_l - lo_l) * int'(sig)) / 64);
   endfunction

   // ***********************************************************
   // divide datapath
   // ***********************************************************
   function automatic idsu_rsp_t do_div(input idsu_req_t r);
      logic [127:0] dvd;
      logic [63:0] dvs, q, rm, qmax_u;
      logic signed [127:0] sd, sq, sr;
      logic signed [63:0] ss;
      int w;
      logic neg;
      dvd = 128'h0;
      dvs = 64'h0;
      q = 64'h0;
      rm = 64'h0;
      sd = 128'sh0;
      sq = 128'sh0;
      sr = 128'sh0;
      ss = 64'sh0;
      neg = 1'b0;
      do_div = '0;
      w = 8 << r.width;
      for (int i = 0; i < 64; i++) begin
         if (i < w) begin
            dvd[i] = r.lo[i];
            dvd[i + w] = r.hi[i];
            dvs[i] = r.src[i];
         end
      end
      qmax_u = (w == 64) ? 64'hffffffffffffffff : ((64'h1 << w) - 64'h1);
      do_div.lo = r.lo;
      do_div.hi = r.hi;
      do_div.microcoded = !(ENHANCED && r.width == IDSU_W8); // RULE3 RULE4 RULE5
      if (dvs == 64'h0) begin
         do_div.exc = 1'b1; // RULE13
      end else if (r.op == IDSU_OP_DIVU) begin
         q = 64'((dvd / {64'h0, dvs}) > {64'h0, qmax_u} ? 128'h0 : dvd / {64'h0, dvs});
         rm = 64'(dvd % {64'h0, dvs});
         if ((dvd / {64'h0, dvs}) > {64'h0, qmax_u}) begin
            do_div.exc = 1'b1; // RULE13
         end else begin
            do_div.lo = q; // RULE1
            do_div.hi = rm; // RULE1
         end
      end else begin
         sd = signed'(dvd << (128 - 2 * w)) >>> (128 - 2 * w);
         ss = signed'(dvs << (64 - w)) >>> (64 - w);
         sq = sd / 128'(ss);
         sr = sd % 128'(ss);
         neg = (sq > (128'sh1 <<< (w - 1)) - 128'sh1) || (sq < -(128'sh1 <<< (w - 1)));
         if (neg) begin
            do_div.exc = 1'b1; // RULE13
         end else begin
            do_div.lo = 64'(sq) & qmax_u; // RULE2
            do_div.hi = 64'(sr) & qmax_u; // RULE2
         end
      end
   endfunction

   // ***********************************************************
   // double shift datapath
   // ***********************************************************
   function automatic idsu_rsp_t do_shift(input idsu_req_t r);
      logic [127:0] cat;
      logic [63:0] res;
      int w, n;
      cat = 128'h0;
      res = 64'h0;
      do_shift = '0;
      w = (r.width == IDSU_W64) ? 64 : ((r.width == IDSU_W32) ? 32 : 16);
      n = int'(r.shamt) % w;
      for (int i = 0; i < 64; i++) begin
         if (i < w) begin
            cat[i] = (r.op == IDSU_OP_DSHL) ? r.src[i] : r.lo[i];
            cat[i + w] = (r.op == IDSU_OP_DSHL) ? r.lo[i] : r.src[i];
         end
      end
      if (r.op == IDSU_OP_DSHL) begin
         cat = cat << n;
         for (int i = 0; i < 64; i++) begin
            if (i < w) begin
               res[i] = cat[i + w];
            end
         end
      end else begin
         cat = cat >> n;
         res = cat[63:0] & ((w == 64) ? 64'hffffffffffffffff : ((64'h1 << w) - 64'h1));
      end
      do_shift.lo = res;
      do_shift.hi = r.hi;
      if (r.width == IDSU_W64) begin
         do_shift.microcoded = 1'b1; // RULE9
      end else if (r.mem_dst || r.cnt_from_reg) begin
         do_shift.microcoded = 1'b1; // RULE12
      end else if (ENHANCED) begin
         do_shift.microcoded = 1'b0; // RULE10
      end else begin
         do_shift.microcoded = (r.op == IDSU_OP_DSHR); // RULE11
      end
   endfunction

   // ***********************************************************
   // control
   // ***********************************************************
   // one request in flight; the scheduler is stalled by req_ready
   always_comb begin
      s_d = s_q;
      req_ready = (s_q.st == IDSU_IDLE);
      case (s_q.st)
         IDSU_IDLE: begin
            if (req_valid) begin
               s_d.r = req;
               s_d.is_div = (req.op == IDSU_OP_DIVU) || (req.op == IDSU_OP_DIVS);
               if (s_d.is_div) begin
                  s_d.res = do_div(req);
                  s_d.cnt = lat_of(req) - 8'h1;
                  s_d.st = IDSU_RUN;
               end else begin
                  s_d.res = do_shift(req);
                  s_d.cnt = s_d.res.microcoded ? 8'(IDSU_SHIFT_UC_LAT - 1) : 8'(IDSU_SHIFT_HW_LAT - 1);
                  s_d.st = (req.cnt_from_reg && req.cnt_fresh) ? IDSU_BUBBLE : IDSU_RUN; // RULE8
               end
               if (s_d.st == IDSU_RUN && s_d.cnt == 8'h0) begin
                  s_d.st = IDSU_DONE;
               end
            end
         end
         IDSU_BUBBLE: begin
            s_d.st = (s_q.cnt == 8'h0) ? IDSU_DONE : IDSU_RUN; // RULE8
         end
         IDSU_RUN: begin
            s_d.cnt = s_q.cnt - 8'h1;
            if (s_q.cnt == 8'h1) begin
               s_d.st = IDSU_DONE;
            end
         end
         IDSU_DONE: begin
            if (rsp_ready) begin
               s_d.st = IDSU_IDLE; // RULE6
            end
         end
         default: begin
            s_d.st = IDSU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{st: IDSU_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp_valid = (s_q.st == IDSU_DONE); // RULE6
   assign rsp = s_q.res;
   assign div_busy = s_q.is_div && (s_q.st == IDSU_RUN || s_q.st == IDSU_DONE); // RULE7
endmodule

// File: dv/idsu_unit_sva.sv
// port assertions for the divide and double-shift unit
`timescale 1ns/1ns
module idsu_unit_sva
   import idsu_pkg::*;
#(
   parameter bit ENHANCED = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   input idsu_req_t req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input idsu_rsp_t rsp,
   input wire logic div_busy
);
   // ****
   // handshake and latency
   // ****
   logic tk, dv, sh;
   assign tk = req_valid && req_ready;
   assign dv = req.op[2:1] == 2'h0;
   // count-register shifts kept apart, a fresh count register carries the bubble
   assign sh = tk && !dv && !req.cnt_from_reg && req.width[1];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_byte_lat: assert property (tk && dv && req.width == IDSU_W8 && ENHANCED |=>
      (!rsp_valid) [*8] ##1 (!rsp_valid) [*2] ##[1:2] rsp_valid && !rsp.microcoded) else $error("byte divide latency");
   a_wide_lat: assert property (tk && dv && req.width == IDSU_W64 && ENHANCED |=>
      (!rsp_valid) [*8] ##1 (!rsp_valid) [*3] ##[1:30] rsp_valid && rsp.microcoded) else $error("wide divide");
   a_shift_hw: assert property (sh && !req.width[0] && !req.mem_dst && ENHANCED |=>
      rsp_valid && !rsp.microcoded) else $error("hardware shift");
   a_shift_uc: assert property (sh && (req.width[0] || req.mem_dst) |=>
      (!rsp_valid) [*7] ##1 rsp_valid && rsp.microcoded) else $error("microcoded shift");
   a_count_gap: assert property (tk && !dv && req.cnt_from_reg && req.cnt_fresh && req.width[1] |=>
      (!rsp_valid) [*8] ##1 rsp_valid && rsp.microcoded) else $error("count bubble");
   a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
      else $error("result dropped");
   a_ready_back: assert property (rsp_valid && rsp_ready |=> req_ready && !rsp_valid)
      else $error("not idle after result");
   a_busy_mark: assert property (tk |=> !req_ready && div_busy == $past(dv))
      else $error("busy level");
   a_zero_exc: assert property (tk && dv && req.src == 64'h0 |-> ##[1:135] rsp_valid && rsp.exc)
      else $error("zero divisor");
endmodule
bind idsu_unit idsu_unit_sva #(.ENHANCED(ENHANCED)) u_sva (.clk(clk), .nrst(nrst), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .div_busy(div_busy));

// File: dv/idsu_sched_model.sv
// result side of the core scheduler
`timescale 1ns/1ns
module idsu_sched_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic rsp_valid,
   input wire logic [3:0] stall,
   output logic rsp_ready
);
   // ****
   // stalling consumer
   // ****
   logic [3:0] wait_q;
   // ready only after the stall, so the unit must hold its result
   assign rsp_ready = rsp_valid && wait_q == stall;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_q <= 4'h0;
      end else begin
         wait_q <= (rsp_valid && !rsp_ready) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule

// File: dv/tb_integer_divide_shift_unit.sv
// self-checking bench for the divide and double-shift unit
`timescale 1ns/1ns
module tb_integer_divide_shift_unit;
   import idsu_pkg::*;
   // ****
   // harness
   // ****
   logic clk, nrst, req_valid, req_ready, rsp_valid, rsp_ready, div_busy;
   logic [3:0] stall;
   idsu_req_t req;
   idsu_rsp_t rsp, r_seen;
   int n_mismatch, checks_done, lat;
   // second unit in the baseline variant, result always accepted
   logic b_valid, b_rsp_valid, b_rsp_ready;
   idsu_req_t b_req;
   idsu_rsp_t b_rsp;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   idsu_unit #(.ENHANCED(1'b1)) u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .div_busy(div_busy));
   idsu_sched_model u_sched (.clk(clk), .nrst(nrst), .rsp_valid(rsp_valid), .stall(stall), .rsp_ready(rsp_ready));
   idsu_unit #(.ENHANCED(1'b0)) u_dut_base (.clk(clk), .nrst(nrst), .req_valid(b_valid), .req(b_req),
      .req_ready(), .rsp_valid(b_rsp_valid), .rsp_ready(b_rsp_ready), .rsp(b_rsp), .div_busy());
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one whole transfer, bounded waits; a hang ends the run
   task automatic run(input idsu_req_t q, input logic busy, input logic [3:0] st);
      int n, m;
      @(posedge clk);
      req <= q;
      req_valid <= 1'b1;
      stall <= st;
      @(negedge clk);
      for (n = 0; req_ready !== 1'b1 && n < 300; n++) @(negedge clk);
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      chk(64'(req_ready), 64'h0);
      chk(64'(div_busy), 64'(busy));
      for (lat = 1; rsp_valid !== 1'b1 && lat < 300; lat++) @(negedge clk);
      for (m = 0; rsp_ready !== 1'b1 && m < 300; m++) @(negedge clk);
      if (n + lat + m >= 300) begin
         n_mismatch++;
         test_done;
      end
      r_seen = rsp;
      @(posedge clk);
   endtask
   // ****
   // scenarios
   // ****
   task automatic s_div_unsigned;
      idsu_req_t q;
      q = '0;
      q.lo = 64'h64;
      q.src = 64'h7;
      for (int w = 0; w < 4; w++) begin
         q.width = idsu_width_t'(w);
         run(q, 1'b1, 4'(w));
         chk(r_seen.lo, 64'he);
         chk(r_seen.hi, 64'h2);
         chk(64'(r_seen.microcoded), 64'(w != 0));
      end
   endtask
   task automatic s_div_signed;
      idsu_req_t q;
      q = '0;
      q.op = IDSU_OP_DIVS;
      q.width = IDSU_W32;
      q.hi = 64'hffffffff;
      q.lo = 64'hffffff9c;
      q.src = 64'h7;
      run(q, 1'b1, 4'h1);
      chk(r_seen.lo, 64'hfffffff2);
      chk(r_seen.hi, 64'hfffffffe);
   endtask
   // zero divisor, then a byte quotient that cannot fit
   task automatic s_div_fault;
      idsu_req_t q;
      q = '0;
      q.width = IDSU_W16;
      q.hi = 64'h3;
      q.lo = 64'h5;
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            q.width = IDSU_W8;
            q.hi = 64'h10;
            q.src = 64'h1;
         end
         run(q, 1'b1, 4'h2);
         chk(64'(r_seen.exc), 64'h1);
         chk(r_seen.lo, q.lo);
         chk(r_seen.hi, q.hi);
      end
   endtask
   task automatic s_shift;
      idsu_req_t q;
      logic [63:0] e [6];
      int el [6];
      e = '{64'h3456789a, 64'hf0123456, 64'h1234567800, 64'hf000000000123456, 64'h3456789a, 64'hf0123456};
      el = '{IDSU_SHIFT_HW_LAT, IDSU_SHIFT_HW_LAT, IDSU_SHIFT_UC_LAT, IDSU_SHIFT_UC_LAT, IDSU_SHIFT_UC_LAT,
         IDSU_SHIFT_UC_LAT + 1};
      q = '0;
      q.lo = 64'h12345678;
      q.src = 64'h9abcdef0;
      q.shamt = 8'h08;
      for (int k = 0; k < 6; k++) begin
         q.op = k[0] ? IDSU_OP_DSHR : IDSU_OP_DSHL;
         q.width = (k == 2 || k == 3) ? IDSU_W64 : IDSU_W32;
         q.mem_dst = k == 4;
         q.cnt_from_reg = k == 5;
         q.cnt_fresh = k == 5;
         run(q, 1'b0, 4'(k));
         chk(q.width[0] ? r_seen.lo : 64'(r_seen.lo[31:0]), e[k]);
         chk(64'(r_seen.microcoded), 64'(k > 1));
         chk(64'(lat), 64'(el[k]));
      end
   endtask
   // baseline: fixed byte divide latencies, right double shift microcoded
   task automatic s_baseline;
      idsu_req_t q;
      idsu_op_t ops [4];
      int el [4];
      ops = '{IDSU_OP_DSHR, IDSU_OP_DSHL, IDSU_OP_DIVU, IDSU_OP_DIVS};
      el = '{IDSU_SHIFT_UC_LAT, IDSU_SHIFT_HW_LAT, IDSU_BU_B, IDSU_BS_B};
      q = '0;
      q.shamt = 8'h08;
      for (int k = 0; k < 4; k++) begin
         q.op = ops[k];
         q.width = (k > 1) ? IDSU_W8 : IDSU_W32;
         q.lo = (k > 1) ? 64'h64 : 64'h12345678;
         q.src = (k > 1) ? 64'h7 : 64'h9abcdef0;
         @(posedge clk);
         b_req <= q;
         b_valid <= 1'b1;
         @(posedge clk);
         b_valid <= 1'b0;
         @(negedge clk);
         for (lat = 1; b_rsp_valid !== 1'b1 && lat < 300; lat++) @(negedge clk);
         chk(64'(lat), 64'(el[k]));
         if (lat >= 300) begin
            test_done;
         end
         chk(64'(b_rsp.microcoded), 64'(k != 1));
         chk(b_rsp.lo, (k > 1) ? 64'he : ((k == 0) ? 64'hf0123456 : 64'h3456789a));
         chk(b_rsp.hi, (k > 1) ? 64'h2 : 64'h0);
         @(posedge clk);
      end
   endtask
   initial begin
      nrst = 1'b0;
      req_valid = 1'b0;
      req = '0;
      stall = 4'h0;
      b_valid = 1'b0;
      b_req = '0;
      b_rsp_ready = 1'b1;
      n_mismatch = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      chk(64'(rsp_valid), 64'h0);
      chk(64'(div_busy), 64'h0);
      nrst <= 1'b1;
      s_div_unsigned;
      s_div_signed;
      s_div_fault;
      s_shift;
      s_baseline;
      test_done;
   end
endmodule
